// file: iop_far_end.sv
/*
 * Far-side model of one port: external devices and the board pull-up.
 * Assumes the pin is driven by the block when oe_n is low, else by ext_en.
 */
module iop_far_end #(
    parameter int W = 8
) (
    input wire logic [W-1:0] drv_i,
    input wire logic [W-1:0] oe_n_i,
    input wire logic [W-1:0] ext_en_i,
    input wire logic [W-1:0] ext_val_i,
    output logic [W-1:0] level_o
);
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!oe_n_i[i]) begin
                level_o[i] = drv_i[i];
            end else if (ext_en_i[i]) begin
                level_o[i] = ext_val_i[i];
            end else begin
                // released pin floats up: open-drain needs the pull-up
                level_o[i] = 1'b1;
            end
        end
    end
endmodule

// file: iop_pin_if.sv
/*
 * Carrier between the register/control logic and one port's pin logic.
 * Assumes one instance per port, all eight bits wide.
 */
interface iop_pin_if;
    logic [7:0] dir;
    logic [7:0] mode;
    logic [7:0] dout;
    logic [7:0] oe_term;
    logic [7:0] addr;
    logic [7:0] ovr_en;
    logic [7:0] ovr_out;
    logic [7:0] ovr_oe;
    logic [7:0] od;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    logic [7:0] drv_en;

    modport port (
        input dir, mode, dout, oe_term, addr, ovr_en, ovr_out, ovr_oe, od,
        output pin_out, pin_oe_n, drv_en
    );
    modport ctl (
        output dir, mode, dout, oe_term, addr, ovr_en, ovr_out, ovr_oe, od,
        input pin_out, pin_oe_n, drv_en
    );
endinterface

// file: iop_pkg.sv
/*
 * Shared constants for the I/O port configuration block: register map,
 * per-port bit masks and reset value.
 * Assumes it is compiled before every other file of the block.
 */
package iop_pkg;
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;
    localparam int MODE_PORTS = 2;

    typedef logic [NUM_PORTS-1:0][PORT_W-1:0] iop_bank_t;

    localparam logic [7:0] REG_RESET = 8'h00;

    // config space layout: bits 5:4 pick the port, bits 3:0 the register
    localparam logic [1:0] PORT_SPACE = 2'h0;
    localparam logic [3:0] OFS_DATA_IN = 4'h0;
    localparam logic [3:0] OFS_DATA_OUT = 4'h1;
    localparam logic [3:0] OFS_DIR = 4'h2;
    localparam logic [3:0] OFS_DRIVE = 4'h3;
    localparam logic [3:0] OFS_MODE = 4'h4;
    localparam logic [3:0] OFS_ENABLE_OUT = 4'h5;
    localparam logic [ADDR_W-1:0] MISC_ADDR = 8'h40;
    localparam int PERIPH_BIT = 7;

    // index 0 is the first port, index 3 the three-pin port
    localparam iop_bank_t PORT_MASK = {8'h07, 8'hFF, 8'hFF, 8'hFF};
    localparam iop_bank_t OD_MASK = {8'h00, 8'hFF, 8'hF0, 8'hF0};
    localparam iop_bank_t SLEW_MASK = {8'h07, 8'h00, 8'h0F, 8'h0F};
    localparam iop_bank_t DRIVE_MASK = {8'h07, 8'hFF, 8'hFF, 8'hFF};
endpackage

// file: iop_port.sv
/*
 * Pin logic of one port: output mux, driver enable, open-drain handling.
 * Assumes configuration arrives already masked to the bits the port has.
 */
module iop_port #(
    parameter bit HAS_MODE = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    iop_pin_if.port pif
);
    import iop_pkg::*;

    logic [7:0] eff_mode;
    logic [7:0] sel_data;
    logic [7:0] en;
    logic [7:0] val;
    logic [7:0] nxt_out;
    logic [7:0] nxt_oe_n;
    logic [7:0] out_ff;
    logic [7:0] oe_n_ff;

    always_comb begin
        eff_mode = HAS_MODE ? pif.mode : 8'h00;
        pif.drv_en = pif.dir | pif.oe_term;
        sel_data = (eff_mode & pif.addr) | (~eff_mode & pif.dout);
        en = (pif.ovr_en & pif.ovr_oe) | (~pif.ovr_en & pif.drv_en);
        val = (pif.ovr_en & pif.ovr_out) | (~pif.ovr_en & sel_data);
        // open drain only ever sinks: a high value releases the pin
        nxt_oe_n = ~(en & ~(pif.od & val));
        nxt_out = val & ~pif.od;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_ff <= REG_RESET;
            oe_n_ff <= 8'hFF;
        end else begin
            out_ff <= nxt_out;
            oe_n_ff <= nxt_oe_n;
        end
    end

    assign pif.pin_out = out_ff;
    assign pif.pin_oe_n = oe_n_ff;

    dir_drives_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pif.ovr_en[0] == 1'b0 && pif.od[0] == 1'b0 && pif.drv_en[0]) |=> !pif.pin_oe_n[0])
        else $error("enabled pin 0 not driven");
    input_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pif.ovr_en[1] == 1'b0 && pif.dir[1] == 1'b0 && pif.oe_term[1] == 1'b0) |=> pif.pin_oe_n[1])
        else $error("input pin 1 driven");
    od_no_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(pif.od[7]) |-> (pif.pin_out[7] == 1'b0))
        else $error("open drain pin drove high");
    mode_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (HAS_MODE && pif.mode[2] && pif.ovr_en[2] == 1'b0 && pif.od[2] == 1'b0)
        |=> (pif.pin_out[2] == $past(pif.addr[2])))
        else $error("address mode pin 2 not carrying address");
endmodule

// file: iop_top.sv
/*
 * Configuration and mode logic of four I/O ports (three of eight pins, one of
 * three pins): config registers, address latching, data port, peripheral
 * buffer and scan pin multiplexing.
 * Assumes all inputs are synchronous to clk_i and that the MCU strobes the
 * config space for one cycle per access.
 */
import iop_pkg::*;

// What this block does
// - mode bit 0 gives general I/O, 1 gives latched address output.
// - only first two ports have mode select; others stay general I/O.
// - direction bit 1 makes output, 0 makes input without oe term.
// - driver enable is direction bit OR output-enable product term.
// - all configuration registers clear to zero at reset.
// - three-pin port direction keeps only its three low bits.
// - bit n of each register acts on pin n of its port.
// - drive-select bit 1 makes open-drain pins sink only.
// - drive-select bit 1 selects fast edges on slew-capable pins.
// - per-port split of open-drain and slew bits in drive select.
// - address out carries a7-a0; non-multiplexed bus uses second port only.
// - pins of the first three ports are captured in input latches on the address strobe.
// - data port mode gives first port to the MCU data bus.
// - misc register bit 7 turns first port into bidirectional buffer.
// - peripheral buffer is tri-stated unless a select term is active.
// - scan pins enabled by select term, stored setting or scan enable.
// - scan functions share third-port pins with other functions.
// - registers reached by plain bus reads and writes, read back as written.
// - data-in read returns the live pin levels.
// - output data register holds, drives and reads back its value.
module iop_top #(
    parameter logic [7:0] SCAN_PIN_MASK = 8'h0F
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cfg_sel_i,
    input wire logic bus_rd_i,
    input wire logic bus_wr_i,
    input wire logic [iop_pkg::ADDR_W-1:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    output logic [7:0] cfg_rdata_o,
    output logic [7:0] ext_rdata_o,
    input wire logic address_strobe_i,
    input wire logic muxed_bus_i,
    input wire logic data_port_mode_i,
    input wire logic periph_select_term_a_i,
    input wire logic periph_select_term_b_i,
    input wire logic scan_pin_select_term_i,
    input wire logic scan_nv_enable_i,
    input wire logic scan_enable_i,
    input wire logic [7:0] scan_out_i,
    input wire logic [7:0] scan_oe_i,
    output logic scan_active_o,
    input wire logic [7:0] oe_term_a_i,
    input wire logic [7:0] oe_term_b_i,
    input wire logic [7:0] oe_term_c_i,
    input wire logic [2:0] oe_term_d_i,
    input wire logic [7:0] pin_a_i,
    output logic [7:0] pin_a_o,
    output logic [7:0] pin_a_oe_n_o,
    input wire logic [7:0] pin_b_i,
    output logic [7:0] pin_b_o,
    output logic [7:0] pin_b_oe_n_o,
    input wire logic [7:0] pin_c_i,
    output logic [7:0] pin_c_o,
    output logic [7:0] pin_c_oe_n_o,
    input wire logic [2:0] pin_d_i,
    output logic [2:0] pin_d_o,
    output logic [2:0] pin_d_oe_n_o,
    output logic [31:0] open_drain_o,
    output logic [31:0] fast_slew_o,
    output logic [23:0] input_macrocell_o
);
    import iop_pkg::*;

    iop_bank_t dout_ff;
    iop_bank_t dir_ff;
    iop_bank_t drive_ff;
    logic [MODE_PORTS-1:0][7:0] mode_ff;
    logic [7:0] misc_config_reg_ff;
    logic [7:0] rdata_ff;
    logic [7:0] ext_rdata_ff;
    logic strobe_q_ff;
    logic [7:0] addr_lat_ff;
    logic [2:0][7:0] imc_ff;

    iop_bank_t nxt_dout;
    iop_bank_t nxt_dir;
    iop_bank_t nxt_drive;
    logic [MODE_PORTS-1:0][7:0] nxt_mode;
    logic [7:0] nxt_misc_config_reg;
    logic [7:0] nxt_rdata;
    logic [7:0] nxt_ext_rdata;
    logic nxt_strobe_q;
    logic [7:0] nxt_addr_lat;
    logic [2:0][7:0] nxt_imc;

    iop_bank_t pin_in;
    iop_bank_t oe_term;
    iop_bank_t addr_bank;
    iop_bank_t ovr_en;
    iop_bank_t ovr_out;
    iop_bank_t ovr_oe;
    iop_bank_t drv_en;
    iop_bank_t pin_out;
    iop_bank_t pin_oe_n;

    logic port_hit;
    logic misc_hit;
    logic [1:0] port_sel;
    logic [3:0] reg_sel;
    logic strobe_rise;
    logic ext_wr;
    logic periph_buffer_enable_bit;
    logic periph_sel;
    logic scan_en;
    logic [7:0] rd_val;

    assign pin_in = {{5'h00, pin_d_i}, pin_c_i, pin_b_i, pin_a_i};
    assign oe_term = {{5'h00, oe_term_d_i}, oe_term_c_i, oe_term_b_i, oe_term_a_i};

    assign port_sel = bus_addr_i[5:4];
    assign reg_sel = bus_addr_i[3:0];
    assign port_hit = cfg_sel_i && (bus_addr_i[7:6] == PORT_SPACE);
    assign misc_hit = cfg_sel_i && (bus_addr_i == MISC_ADDR);
    assign strobe_rise = address_strobe_i && !strobe_q_ff;
    // cycles outside the config space are the external data cycles
    assign ext_wr = bus_wr_i && !cfg_sel_i;
    assign periph_buffer_enable_bit = misc_config_reg_ff[PERIPH_BIT];
    assign periph_sel = periph_select_term_a_i || periph_select_term_b_i;
    assign scan_en = scan_pin_select_term_i || scan_nv_enable_i || scan_enable_i;

    // register read mux: unmapped offsets and missing bits read as zero
    always_comb begin
        rd_val = 8'h00;
        if (misc_hit) begin
            rd_val = misc_config_reg_ff;
        end else if (port_hit) begin
            unique case (reg_sel)
                OFS_DATA_IN: rd_val = pin_in[port_sel] & PORT_MASK[port_sel];
                OFS_DATA_OUT: rd_val = dout_ff[port_sel];
                OFS_DIR: rd_val = dir_ff[port_sel];
                OFS_DRIVE: rd_val = drive_ff[port_sel];
                OFS_MODE: rd_val = port_sel[1] ? 8'h00 : mode_ff[port_sel[0]];
                OFS_ENABLE_OUT: rd_val = drv_en[port_sel] & PORT_MASK[port_sel];
                default: rd_val = 8'h00;
            endcase
        end
    end

    always_comb begin
        nxt_dout = dout_ff;
        nxt_dir = dir_ff;
        nxt_drive = drive_ff;
        nxt_mode = mode_ff;
        nxt_misc_config_reg = misc_config_reg_ff;
        nxt_rdata = rdata_ff;
        nxt_ext_rdata = pin_a_i;
        nxt_strobe_q = address_strobe_i;
        nxt_addr_lat = addr_lat_ff;
        nxt_imc = imc_ff;
        if (bus_wr_i && misc_hit) begin
            nxt_misc_config_reg = bus_wdata_i;
        end else if (bus_wr_i && port_hit) begin
            unique case (reg_sel)
                OFS_DATA_OUT: nxt_dout[port_sel] = bus_wdata_i & PORT_MASK[port_sel];
                OFS_DIR: nxt_dir[port_sel] = bus_wdata_i & PORT_MASK[port_sel];
                OFS_DRIVE: nxt_drive[port_sel] = bus_wdata_i & DRIVE_MASK[port_sel];
                OFS_MODE: begin
                    if (!port_sel[1]) begin
                        nxt_mode[port_sel[0]] = bus_wdata_i;
                    end
                end
                default: begin
                end
            endcase
        end
        if (bus_rd_i && cfg_sel_i) begin
            nxt_rdata = rd_val;
        end
        // one capture per strobe; the low address byte is held for address out
        if (strobe_rise) begin
            nxt_addr_lat = bus_addr_i[7:0];
            nxt_imc = {pin_c_i, pin_b_i, pin_a_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dout_ff <= '0;
            dir_ff <= '0;
            drive_ff <= '0;
            mode_ff <= '0;
            misc_config_reg_ff <= REG_RESET;
            rdata_ff <= REG_RESET;
            ext_rdata_ff <= REG_RESET;
            strobe_q_ff <= 1'b0;
            addr_lat_ff <= REG_RESET;
            imc_ff <= '0;
        end else begin
            dout_ff <= nxt_dout;
            dir_ff <= nxt_dir;
            drive_ff <= nxt_drive;
            mode_ff <= nxt_mode;
            misc_config_reg_ff <= nxt_misc_config_reg;
            rdata_ff <= nxt_rdata;
            ext_rdata_ff <= nxt_ext_rdata;
            strobe_q_ff <= nxt_strobe_q;
            addr_lat_ff <= nxt_addr_lat;
            imc_ff <= nxt_imc;
        end
    end

    // bus modes own the first port; scan takes only its chosen third-port pins
    always_comb begin
        addr_bank = '0;
        ovr_en = '0;
        ovr_out = '0;
        ovr_oe = '0;
        addr_bank[0] = muxed_bus_i ? addr_lat_ff : dout_ff[0];
        addr_bank[1] = addr_lat_ff;
        if (data_port_mode_i) begin
            ovr_en[0] = 8'hFF;
            ovr_out[0] = bus_wdata_i;
            ovr_oe[0] = {8{ext_wr}};
        end else if (periph_buffer_enable_bit) begin
            ovr_en[0] = 8'hFF;
            ovr_out[0] = bus_wdata_i;
            ovr_oe[0] = {8{periph_sel && ext_wr}};
        end
        ovr_en[2] = SCAN_PIN_MASK & {8{scan_en}};
        ovr_out[2] = scan_out_i;
        ovr_oe[2] = scan_oe_i;
    end

    iop_pin_if pif[NUM_PORTS] ();

    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
        assign pif[g].dir = dir_ff[g];
        assign pif[g].mode = (g < MODE_PORTS) ? mode_ff[g % MODE_PORTS] : 8'h00;
        assign pif[g].dout = dout_ff[g];
        assign pif[g].oe_term = oe_term[g] & PORT_MASK[g];
        assign pif[g].addr = addr_bank[g];
        assign pif[g].ovr_en = ovr_en[g];
        assign pif[g].ovr_out = ovr_out[g];
        assign pif[g].ovr_oe = ovr_oe[g];
        assign pif[g].od = drive_ff[g] & OD_MASK[g];
        assign pin_out[g] = pif[g].pin_out;
        assign pin_oe_n[g] = pif[g].pin_oe_n;
        assign drv_en[g] = pif[g].drv_en;
        assign open_drain_o[g*8 +: 8] = drive_ff[g] & OD_MASK[g];
        assign fast_slew_o[g*8 +: 8] = drive_ff[g] & SLEW_MASK[g];
        iop_port #(
            .HAS_MODE(g < MODE_PORTS)
        ) u_port (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .pif(pif[g])
        );
    end

    assign pin_a_o = pin_out[0];
    assign pin_a_oe_n_o = pin_oe_n[0];
    assign pin_b_o = pin_out[1];
    assign pin_b_oe_n_o = pin_oe_n[1];
    assign pin_c_o = pin_out[2];
    assign pin_c_oe_n_o = pin_oe_n[2];
    assign pin_d_o = pin_out[3][2:0];
    assign pin_d_oe_n_o = pin_oe_n[3][2:0];
    assign cfg_rdata_o = rdata_ff;
    assign ext_rdata_o = ext_rdata_ff;
    assign scan_active_o = scan_en;
    assign input_macrocell_o = imc_ff;

    dir_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_wr_i && port_hit && reg_sel == OFS_DIR && port_sel == 2'h1)
        ##1 (bus_rd_i && port_hit && reg_sel == OFS_DIR && port_sel == 2'h1 && !bus_wr_i)
        |=> (cfg_rdata_o == $past(bus_wdata_i, 2)))
        else $error("direction read back differs from write");
    d_dir_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dir_ff[3][7:3] == 5'h00)
        else $error("three-pin port direction upper bits set");
    reset_clear_a: assert property (@(posedge clk_i)
        $past(rst_i) |-> (dir_ff == '0 && mode_ff == '0 && drive_ff == '0 && pin_a_oe_n_o == 8'hFF))
        else $error("configuration not cleared by reset");
    data_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_rd_i && port_hit && reg_sel == OFS_DATA_IN && port_sel == 2'h2)
        |=> (cfg_rdata_o == $past(pin_c_i)))
        else $error("data-in read not the pin level");
    addr_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        strobe_rise |=> (addr_lat_ff == $past(bus_addr_i) && imc_ff[1] == $past(pin_b_i)))
        else $error("address strobe capture missed");
    periph_tristate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (periph_buffer_enable_bit && !data_port_mode_i && !periph_sel) |=> (pin_a_oe_n_o == 8'hFF))
        else $error("peripheral buffer driven without select");
    data_port_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (data_port_mode_i && ext_wr) |=> (pin_a_oe_n_o == 8'h00 || drive_ff[0][7:4] != 4'h0))
        else $error("data port did not drive the write cycle");
    scan_mux_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (scan_en && scan_oe_i[0] && !scan_out_i[0] && SCAN_PIN_MASK[0])
        |=> (pin_c_oe_n_o[0] == 1'b0 && pin_c_o[0] == 1'b0))
        else $error("scan pin 0 not handed to scan logic");
    nonmux_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!muxed_bus_i && mode_ff[0][3] && dir_ff[0][3] && !data_port_mode_i
         && !periph_buffer_enable_bit && !drive_ff[0][7])
        |=> (pin_a_o[3] == $past(dout_ff[0][3])))
        else $error("first port carried address on non-multiplexed bus");
endmodule

// file: tb_io_port_config_and_mode_logic.sv
/*
 * Self-checking bench for the four-port configuration block.
 * Assumes the register map and one-stage pin latency of the block.
 */
module tb_io_port_config_and_mode_logic;
    timeunit 1ns;
    timeprecision 1ps;
    import iop_pkg::*;
    logic clk, rst, sel, rd, wr, strobe, muxed, dport, psa, psb, scan_act;
    logic [2:0] scn, pd_o, pd_oe_n, lv_d, oe_d;
    logic [7:0] addr, wdata, scan_out, scan_oe, oe_a, oe_b, oe_c, ext_rdata, cfg_rdata;
    logic [7:0] pa_o, pa_oe_n, pb_o, pb_oe_n, pc_o, pc_oe_n, lv_a, lv_b, lv_c;
    logic [31:0] od, slew;
    logic [23:0] input_macrocell;
    logic [7:0] xen [4];
    logic [7:0] xval [4];
    int err_total, compares;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    iop_top DUT (.clk_i(clk), .rst_i(rst), .cfg_sel_i(sel), .bus_rd_i(rd), .bus_wr_i(wr),
        .bus_addr_i(addr), .bus_wdata_i(wdata), .cfg_rdata_o(cfg_rdata), .ext_rdata_o(ext_rdata),
        .address_strobe_i(strobe), .muxed_bus_i(muxed), .data_port_mode_i(dport),
        .periph_select_term_a_i(psa), .periph_select_term_b_i(psb),
        .scan_pin_select_term_i(scn[0]), .scan_nv_enable_i(scn[1]), .scan_enable_i(scn[2]),
        .scan_out_i(scan_out), .scan_oe_i(scan_oe), .scan_active_o(scan_act),
        .oe_term_a_i(oe_a), .oe_term_b_i(oe_b), .oe_term_c_i(oe_c), .oe_term_d_i(oe_d),
        .pin_a_i(lv_a), .pin_a_o(pa_o), .pin_a_oe_n_o(pa_oe_n),
        .pin_b_i(lv_b), .pin_b_o(pb_o), .pin_b_oe_n_o(pb_oe_n),
        .pin_c_i(lv_c), .pin_c_o(pc_o), .pin_c_oe_n_o(pc_oe_n),
        .pin_d_i(lv_d), .pin_d_o(pd_o), .pin_d_oe_n_o(pd_oe_n),
        .open_drain_o(od), .fast_slew_o(slew), .input_macrocell_o(input_macrocell));

    iop_far_end #(.W(8)) far_a (.drv_i(pa_o), .oe_n_i(pa_oe_n), .ext_en_i(xen[0]), .ext_val_i(xval[0]),
        .level_o(lv_a));
    iop_far_end #(.W(8)) far_b (.drv_i(pb_o), .oe_n_i(pb_oe_n), .ext_en_i(xen[1]), .ext_val_i(xval[1]),
        .level_o(lv_b));
    iop_far_end #(.W(8)) far_c (.drv_i(pc_o), .oe_n_i(pc_oe_n), .ext_en_i(xen[2]), .ext_val_i(xval[2]),
        .level_o(lv_c));
    iop_far_end #(.W(3)) far_d (.drv_i(pd_o), .oe_n_i(pd_oe_n), .ext_en_i(xen[3][2:0]), .ext_val_i(xval[3][2:0]),
        .level_o(lv_d));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sel <= 1'b1; wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        sel <= 1'b0; wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge clk);
        sel <= 1'b1; rd <= 1'b1; addr <= a;
        @(posedge clk);
        sel <= 1'b0; rd <= 1'b0;
        #1;
        chk(cfg_rdata, e, what);
    endtask

    task automatic strobe_addr(input logic [7:0] a);
        @(posedge clk);
        addr <= a; strobe <= 1'b1;
        @(posedge clk);
        strobe <= 1'b0;
        tick(2);
    endtask

    // external data write cycle; released pins must be tri-stated afterwards
    task automatic ext_wr(input logic [7:0] d, input logic [7:0] e_oe_n, input string what);
        @(posedge clk);
        wr <= 1'b1; wdata <= d;
        tick(2);
        chk(pa_oe_n, e_oe_n, what);
        if (e_oe_n == 8'h00) chk(pa_o, d, what);
        @(posedge clk);
        wr <= 1'b0;
        tick(2);
        chk(pa_oe_n, 8'hFF, what);
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("MISMATCH t=%0t run did not complete", $time);
        wrap_up();
    end

    initial begin
        {rst, sel, rd, wr, strobe, muxed, dport, psa, psb} = 9'h100;
        {scn, addr, wdata, scan_out, scan_oe, oe_a, oe_b, oe_c, oe_d} = '0;
        for (int p = 0; p < 4; p++) begin
            xen[p] = 8'h00;
            xval[p] = 8'h00;
        end
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk({pa_oe_n, pb_oe_n, pc_oe_n, pd_oe_n}, 27'h7FFFFFF, "pins input after reset");
        for (int p = 0; p < 4; p++) begin
            rd_chk({2'h0, 2'(p), OFS_DIR}, 8'h00, "dir reset");
            rd_chk({2'h0, 2'(p), OFS_DRIVE}, 8'h00, "drive reset");
            rd_chk({2'h0, 2'(p), OFS_MODE}, 8'h00, "mode reset");
        end
        done("reset");

        for (int p = 0; p < 4; p++) begin
            reg_wr({2'h0, 2'(p), OFS_DIR}, 8'hFF);
            reg_wr({2'h0, 2'(p), OFS_DRIVE}, 8'hFF);
            reg_wr({2'h0, 2'(p), OFS_MODE}, 8'hFF);
            reg_wr({2'h0, 2'(p), OFS_DATA_OUT}, 8'hFF);
        end
        reg_wr(8'h0F, 8'h5A);
        for (int p = 0; p < 4; p++) begin
            rd_chk({2'h0, 2'(p), OFS_DIR}, (p == 3) ? 8'h07 : 8'hFF, "dir readback");
            rd_chk({2'h0, 2'(p), OFS_DRIVE}, (p == 3) ? 8'h07 : 8'hFF, "drive readback");
            rd_chk({2'h0, 2'(p), OFS_MODE}, (p < 2) ? 8'hFF : 8'h00, "mode readback");
            rd_chk({2'h0, 2'(p), OFS_DATA_OUT}, (p == 3) ? 8'h07 : 8'hFF, "data out readback");
        end
        rd_chk(8'h0F, 8'h00, "unmapped offset");
        @(posedge clk);
        sel <= 1'b1;
        wr <= 1'b1;
        addr <= 8'h12;
        wdata <= 8'h3C;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        sel <= 1'b0;
        rd <= 1'b0;
        #1;
        chk(cfg_rdata, 8'h3C, "back to back write read");
        chk(od, 32'h00FFF0F0, "open drain map");
        chk(slew, 32'h07000F0F, "fast slew map");
        for (int p = 0; p < 4; p++) begin
            reg_wr({2'h0, 2'(p), OFS_DIR}, 8'h00);
            reg_wr({2'h0, 2'(p), OFS_DRIVE}, 8'h00);
            reg_wr({2'h0, 2'(p), OFS_MODE}, 8'h00);
        end
        tick(2);
        chk(od | slew, 32'h0, "drive bits cleared");
        done("registers");

        reg_wr({4'h0, OFS_DIR}, 8'h05);
        @(posedge clk);
        oe_a <= 8'h30;
        tick(2);
        chk(pa_oe_n, 8'hCA, "dir or oe term");
        rd_chk({4'h0, OFS_ENABLE_OUT}, 8'h35, "enable out");
        @(posedge clk);
        oe_a <= 8'h00;
        tick(2);
        chk(pa_oe_n, 8'hFA, "dir alone");
        reg_wr({4'h0, OFS_DATA_OUT}, 8'hA5);
        reg_wr({4'h0, OFS_DIR}, 8'hFF);
        reg_wr({4'h0, OFS_DRIVE}, 8'hF0);
        tick(2);
        chk(pa_oe_n, 8'hA0, "open drain releases ones");
        chk(pa_o[3:0], 4'h5, "push-pull data");
        rd_chk({4'h0, OFS_DATA_IN}, 8'hA5, "pin levels");
        reg_wr({4'h0, OFS_DIR}, 8'h00);
        reg_wr({4'h0, OFS_DRIVE}, 8'h00);
        oe_b <= 8'h81;
        oe_c <= 8'h42;
        oe_d <= 3'h5;
        tick(2);
        chk(pb_oe_n, 8'h7E, "oe term port b");
        chk(pc_oe_n, 8'hBD, "oe term port c");
        chk(pd_oe_n, 3'h2, "oe term port d");
        chk(pd_o, 3'h7, "port d data out");
        rd_chk({4'h3, OFS_ENABLE_OUT}, 8'h05, "enable out d");
        oe_b <= 8'h00;
        oe_c <= 8'h00;
        oe_d <= 3'h0;
        done("direction and drive");

        xen[0] = 8'hFF; xen[1] = 8'hFF; xen[2] = 8'hFF;
        xval[0] = 8'h11; xval[1] = 8'h22; xval[2] = 8'h44;
        tick(2);
        rd_chk({4'h2, OFS_DATA_IN}, 8'h44, "data in port c");
        strobe_addr(8'h5A);
        chk(input_macrocell, 24'h442211, "input latch");
        xval[0] = 8'h00; xval[1] = 8'h00; xval[2] = 8'h00;
        tick(2);
        chk(input_macrocell, 24'h442211, "latch holds");
        xen[0] = 8'h00; xen[1] = 8'h00; xen[2] = 8'h00;
        done("address in");

        muxed <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            reg_wr({2'h0, 2'(p), OFS_MODE}, 8'hFF);
            reg_wr({2'h0, 2'(p), OFS_DIR}, 8'hFF);
        end
        strobe_addr(8'hC3);
        chk(pa_o, 8'hC3, "address out a");
        chk(pb_o, 8'hC3, "address out b");
        @(posedge clk);
        muxed <= 1'b0;
        reg_wr({4'h0, OFS_DATA_OUT}, 8'h96);
        tick(2);
        chk(pa_o, 8'h96, "non-mux port a data");
        chk(pb_o, 8'hC3, "non-mux port b address");
        @(posedge clk);
        muxed <= 1'b1;
        reg_wr({4'h0, OFS_MODE}, 8'h0F);
        tick(2);
        chk(pa_o, 8'h93, "per pin mode");
        for (int p = 0; p < 2; p++) begin
            reg_wr({2'h0, 2'(p), OFS_MODE}, 8'h00);
            reg_wr({2'h0, 2'(p), OFS_DIR}, 8'h00);
        end
        done("address out");

        xen[0] <= 8'hFF;
        xval[0] <= 8'h9E;
        @(posedge clk);
        dport <= 1'b1;
        tick(2);
        chk(ext_rdata, 8'h9E, "data port read");
        ext_wr(8'h6C, 8'h00, "data port write");
        @(posedge clk);
        dport <= 1'b0;
        reg_wr(MISC_ADDR, 8'h80);
        rd_chk(MISC_ADDR, 8'h80, "misc readback");
        ext_wr(8'h6C, 8'hFF, "buffer idle");
        @(posedge clk);
        psa <= 1'b1;
        ext_wr(8'hA7, 8'h00, "buffer select a");
        @(posedge clk);
        psa <= 1'b0;
        psb <= 1'b1;
        ext_wr(8'h5C, 8'h00, "buffer select b");
        @(posedge clk);
        psb <= 1'b0;
        reg_wr(MISC_ADDR, 8'h00);
        xen[0] <= 8'h00;
        done("data port and buffer");

        @(posedge clk);
        scan_out <= 8'h0A;
        scan_oe <= 8'h0F;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            scn <= (i < 3) ? 3'(1 << i) : 3'h0;
            tick(2);
            chk(scan_act, (i < 3) ? 1'b1 : 1'b0, "scan enable source");
            chk(pc_oe_n, (i < 3) ? 8'hF0 : 8'hFF, "scan pin enable");
            if (i < 3) chk(pc_o[3:0], 4'hA, "scan pin value");
        end
        done("scan");
        wrap_up();
    end
endmodule
